// ===== design/icr_core.v
`timescale 1ns/10ps
`include "icr_defines.vh"

module icr_core (
  // Clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // SPI host port
  input wire i_chip_select_n,
  input wire i_sclk,
  input wire i_sdi,
  output wire o_sdo,
  output wire o_sdo_oe_n,
  // Sensor and reference clock
  input wire i_reference_clock_in,
  input wire i_sensor_osc,
  input wire i_no_sensor_osc,
  input wire i_fault,
  // Comparator events
  input wire i_inductance_hysteresis_compare,
  input wire i_inductance_high_event,
  input wire i_impedance_hysteresis_compare,
  input wire i_impedance_high_event,
  // Sensor drive and status
  output wire o_fixed_drive_en,
  output wire [2:0] o_min_impedance_drive_code,
  output wire [7:0] o_drive_level,
  output wire o_interrupt_out_n
);

  localparam SB_CS = 0, SB_SCK = 1, SB_SDI = 2, SB_REF = 3, SB_SEN = 4, SB_NOSC = 5;
  localparam SB_FLT = 6, SB_LHY = 7, SB_LHI = 8, SB_RHY = 9, SB_RHI = 10, NSYNC = 11, CW = 20;
  localparam ST_IDLE = 2'h0, ST_MEAS = 2'h1, ST_PROC = 2'h2;
  // Synchronisers reset to each pin's idle level, so no false edge or latch follows reset
  localparam [NSYNC-1:0] SYNC_IDLE = `ICR_SYNC_IDLE;
  reg [NSYNC-1:0] sync1_ff, sync2_ff, sync3_ff;
  wire [NSYNC-1:0] pin_in;
  assign pin_in = {i_impedance_high_event, i_impedance_hysteresis_compare, i_inductance_high_event,
                   i_inductance_hysteresis_compare, i_fault, i_no_sensor_osc, i_sensor_osc,
                   i_reference_clock_in, i_sdi, i_sclk, i_chip_select_n};

  // Two-stage synchronisers per pin, third stage only for edge finding
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sync1_ff[gi] <= SYNC_IDLE[gi];
          sync2_ff[gi] <= SYNC_IDLE[gi];
          sync3_ff[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_ff[gi] <= pin_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  wire cs_n = sync2_ff[SB_CS];
  wire cs_fall = ~sync2_ff[SB_CS] & sync3_ff[SB_CS];
  wire sck_rise = sync2_ff[SB_SCK] & ~sync3_ff[SB_SCK];
  wire sck_fall = ~sync2_ff[SB_SCK] & sync3_ff[SB_SCK];
  wire ref_rise = sync2_ff[SB_REF] & ~sync3_ff[SB_REF];
  wire sen_rise = sync2_ff[SB_SEN] & ~sync3_ff[SB_SEN];
  // Register file
  reg [7:0] drive_set_ff, dig_cfg_ff, alt_cfg_ff, irq_mode_ff, amp_cfg_ff, hr_cfg_ff;
  reg [15:0] ref_count_value_ff, freq_ofs_ff;
  reg [23:0] result_ff;
  // SPI state
  reg [2:0] bit_cnt_ff;
  reg cmd_phase_ff, rd_mode_ff, read_act_ff, sdo_ff, sdo_oe_n_ff;
  reg [6:0] addr_ff, rx_ff;
  reg [7:0] tx_ff, rd_data;
  reg [3:0] fall_cnt_ff;
  wire byte_done = sck_rise & (bit_cnt_ff == 3'h7);
  wire [7:0] rx_byte = {rx_ff, sync2_ff[SB_SDI]};
  wire wr_en = byte_done & ~cmd_phase_ff & ~rd_mode_ff & ~cs_n;
  wire tx_load = sck_fall & (bit_cnt_ff == 3'h0) & ~cmd_phase_ff & rd_mode_ff & ~cs_n;
  wire res_read = tx_load & (addr_ff >= `ICR_OFS_RES_LO) & (addr_ff <= `ICR_OFS_RES_HI);
  wire irq_mux = irq_mode_ff[`ICR_IRQ_MUX_BIT];
  // Read data mux, unmapped addresses read zero
  always @* begin
    rd_data = 8'h00;
    if (addr_ff == `ICR_OFS_SENSOR_DRIVE) rd_data = drive_set_ff;
    else if (addr_ff == `ICR_OFS_DIG_CONV_CFG) rd_data = dig_cfg_ff;
    else if (addr_ff == `ICR_OFS_ALT_CFG) rd_data = alt_cfg_ff;
    else if (addr_ff == `ICR_OFS_IRQ_MODE) rd_data = irq_mode_ff;
    else if (addr_ff == `ICR_OFS_AMP_CFG) rd_data = amp_cfg_ff;
    else if (addr_ff == `ICR_OFS_REFCNT_LO) rd_data = ref_count_value_ff[7:0];
    else if (addr_ff == `ICR_OFS_REFCNT_HI) rd_data = ref_count_value_ff[15:8];
    else if (addr_ff == `ICR_OFS_FOFS_LO) rd_data = freq_ofs_ff[7:0];
    else if (addr_ff == `ICR_OFS_FOFS_HI) rd_data = freq_ofs_ff[15:8];
    else if (addr_ff == `ICR_OFS_HR_CFG) rd_data = hr_cfg_ff;
    else if (addr_ff == `ICR_OFS_RES_LO) rd_data = result_ff[7:0];
    else if (addr_ff == `ICR_OFS_RES_MID) rd_data = result_ff[15:8];
    else if (addr_ff == `ICR_OFS_RES_HI) rd_data = result_ff[23:16];
  end

  // SPI mode 0 engine: command byte (read bit, 7-bit address), then auto-increment data
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_ff <= 3'h0;
      cmd_phase_ff <= 1'b1;
      rd_mode_ff <= 1'b0;
      addr_ff <= 7'h00;
      rx_ff <= 7'h00;
      tx_ff <= 8'h00;
      fall_cnt_ff <= 4'h0;
      read_act_ff <= 1'b0;
    end else if (cs_n) begin
      bit_cnt_ff <= 3'h0;
      cmd_phase_ff <= 1'b1;
      rd_mode_ff <= 1'b0;
      fall_cnt_ff <= 4'h0;
      read_act_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else begin
      if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        rx_ff <= rx_byte[6:0];
      end
      if (byte_done & cmd_phase_ff) begin
        cmd_phase_ff <= 1'b0;
        rd_mode_ff <= rx_ff[6];
        addr_ff <= rx_byte[6:0];
      end else if (wr_en) begin
        addr_ff <= addr_ff + 7'h01;
      end
      if (sck_fall & (fall_cnt_ff != `ICR_SPI_CMD_FALLS)) fall_cnt_ff <= fall_cnt_ff + 4'h1;
      // Load next read byte ahead of its first rising edge
      if (tx_load) begin
        tx_ff <= rd_data;
        addr_ff <= addr_ff + 7'h01;
        read_act_ff <= 1'b1;
      end else if (sck_fall) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // Configuration writes
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drive_set_ff <= `ICR_RST_BYTE;
      dig_cfg_ff <= `ICR_RST_BYTE;
      alt_cfg_ff <= `ICR_RST_BYTE;
      irq_mode_ff <= `ICR_RST_BYTE;
      amp_cfg_ff <= `ICR_RST_BYTE;
      ref_count_value_ff <= `ICR_RST_WORD;
      freq_ofs_ff <= `ICR_RST_WORD;
      hr_cfg_ff <= `ICR_RST_BYTE;
    end else if (wr_en) begin
      if (addr_ff == `ICR_OFS_SENSOR_DRIVE) drive_set_ff <= rx_byte;
      else if (addr_ff == `ICR_OFS_DIG_CONV_CFG) dig_cfg_ff <= rx_byte;
      else if (addr_ff == `ICR_OFS_ALT_CFG) alt_cfg_ff <= rx_byte;
      else if (addr_ff == `ICR_OFS_IRQ_MODE) irq_mode_ff <= rx_byte;
      else if (addr_ff == `ICR_OFS_AMP_CFG) amp_cfg_ff <= rx_byte;
      else if (addr_ff == `ICR_OFS_REFCNT_LO) ref_count_value_ff[7:0] <= rx_byte;
      else if (addr_ff == `ICR_OFS_REFCNT_HI) ref_count_value_ff[15:8] <= rx_byte;
      else if (addr_ff == `ICR_OFS_FOFS_LO) freq_ofs_ff[7:0] <= rx_byte;
      else if (addr_ff == `ICR_OFS_FOFS_HI) freq_ofs_ff[15:8] <= rx_byte;
      else if (addr_ff == `ICR_OFS_HR_CFG) hr_cfg_ff <= rx_byte;
    end
  end

  // Fixed sensor drive; code 7 strongest, each lower code halves
  assign o_fixed_drive_en = alt_cfg_ff[`ICR_FIXED_DRIVE_BIT] & amp_cfg_ff[`ICR_FIXED_DRIVE_BIT];
  assign o_min_impedance_drive_code = drive_set_ff[2:0];
  assign o_drive_level = o_fixed_drive_en ? (8'h01 << drive_set_ff[2:0]) : 8'h00;

  // Dual conversion length: response cycles divided by three, in sensor cycles
  wire [2:0] resp_code = dig_cfg_ff[2:0];
  wire [2:0] resp_sh = (resp_code < `ICR_RESP_CODE_BASE) ? 3'h0 : (resp_code - `ICR_RESP_CODE_BASE);
  wire [12:0] resp_cycles = `ICR_RESP_MIN_CYC << resp_sh;
  wire [12:0] dual_target = resp_cycles / `ICR_RESP_DIVISOR;
  reg [12:0] dual_cnt_ff;
  reg dual_ready_ff;

  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dual_cnt_ff <= 13'h0000;
      dual_ready_ff <= 1'b0;
    end else begin
      dual_ready_ff <= 1'b0;
      if (sen_rise) begin
        if (dual_cnt_ff >= dual_target - 13'h0001) begin
          dual_cnt_ff <= 13'h0000;
          dual_ready_ff <= 1'b1;
        end else begin
          dual_cnt_ff <= dual_cnt_ff + 13'h0001;
        end
      end
    end
  end

  // Hires measurement: sensor prescaler, window, post-processing and divide
  reg [2:0] pre_ff;
  reg ref_seen_ff, pend_ff;
  reg [1:0] hst_ff;
  reg [CW-1:0] ref_cnt_ff, sens_cnt_ff;
  reg [CW:0] rem_ff;
  reg [CW+23:0] dvd_ff;
  reg [23:0] quo_ff, pend_val_ff;
  reg [5:0] step_ff;
  wire [2:0] pre_mask = (3'h1 << hr_cfg_ff[1:0]) - 3'h1;
  wire div_tick = sen_rise & ((pre_ff & pre_mask) == pre_mask);
  wire [CW-1:0] window = {ref_count_value_ff, {`ICR_HR_CNT_SHIFT{1'b0}}};
  wire [CW:0] rem_try = {rem_ff[CW-1:0], dvd_ff[CW+23]};
  wire rem_ge = rem_try >= {1'b0, window};
  wire [23:0] ofs_scaled = {freq_ofs_ff, 8'h00};

  // Reference count of zero skips the window; divide by zero yields all ones
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_ff <= 3'h0;
      ref_seen_ff <= 1'b0;
      hst_ff <= ST_IDLE;
      ref_cnt_ff <= {CW{1'b0}};
      sens_cnt_ff <= {CW{1'b0}};
      rem_ff <= {(CW+1){1'b0}};
      dvd_ff <= {(CW+24){1'b0}};
      quo_ff <= 24'h000000;
      step_ff <= 6'h00;
      pend_ff <= 1'b0;
      pend_val_ff <= `ICR_RST_RESULT;
    end else begin
      if (sen_rise) pre_ff <= pre_ff + 3'h1;
      if (ref_rise) ref_seen_ff <= 1'b1; // Sticky: one edge proves the reference is there
      if (step_ff != 6'h00) begin
        rem_ff <= rem_ge ? (rem_try - {1'b0, window}) : rem_try;
        dvd_ff <= {dvd_ff[CW+22:0], 1'b0};
        quo_ff <= {quo_ff[22:0], rem_ge};
        step_ff <= step_ff - 6'h01;
      end
      if (pend_ff & cs_n) pend_ff <= 1'b0;
      case (hst_ff)
        ST_IDLE: begin
          if (ref_seen_ff) begin
            hst_ff <= ST_MEAS;
            ref_cnt_ff <= {CW{1'b0}};
            sens_cnt_ff <= {CW{1'b0}};
          end
        end
        ST_MEAS: begin
          if (div_tick) sens_cnt_ff <= sens_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
          if ((ref_cnt_ff >= window) | (ref_rise & (ref_cnt_ff == window - {{(CW-1){1'b0}}, 1'b1}))) begin
            hst_ff <= ST_PROC;
            ref_cnt_ff <= {CW{1'b0}};
            rem_ff <= {(CW+1){1'b0}};
            dvd_ff <= {sens_cnt_ff, 24'h000000};
            step_ff <= `ICR_DIV_STEPS;
          end else if (ref_rise) begin
            ref_cnt_ff <= ref_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        ST_PROC: begin
          if (ref_rise & (ref_cnt_ff == `ICR_HR_POST_CYC - 20'h00001)) begin
            hst_ff <= ST_MEAS;
            ref_cnt_ff <= {CW{1'b0}};
            sens_cnt_ff <= {CW{1'b0}};
            pend_ff <= 1'b1;
            if (sync2_ff[SB_NOSC]) begin
              pend_val_ff <= `ICR_RESULT_NO_OSC;
            end else if (sync2_ff[SB_FLT]) begin
              pend_val_ff <= `ICR_RST_RESULT;
            end else begin
              pend_val_ff <= quo_ff - ofs_scaled;
            end
          end else if (ref_rise) begin
            ref_cnt_ff <= ref_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          hst_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Result lands only while deselected; ready set wins over clear-on-read
  reg hr_ready_ff, l_high_ff, rp_high_ff;
  wire publish = pend_ff & cs_n;
  wire latch_clr = wr_en & (addr_ff == `ICR_OFS_IRQ_MODE) & (rx_byte[5:0] == 6'h00);

  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result_ff <= `ICR_RST_RESULT;
      hr_ready_ff <= 1'b0;
      l_high_ff <= 1'b0;
      rp_high_ff <= 1'b0;
    end else begin
      if (publish) result_ff <= pend_val_ff;
      if (publish) begin
        hr_ready_ff <= 1'b1;
      end else if (res_read) begin
        hr_ready_ff <= 1'b0;
      end
      if (sync2_ff[SB_LHI]) begin
        l_high_ff <= 1'b1;
      end else if (latch_clr) begin
        l_high_ff <= 1'b0;
      end
      if (sync2_ff[SB_RHI]) begin
        rp_high_ff <= 1'b1;
      end else if (latch_clr) begin
        rp_high_ff <= 1'b0;
      end
    end
  end

  // Interrupt source selection, active low
  wire [5:0] irq_src = {hr_ready_ff, sync2_ff[SB_LHY], l_high_ff, dual_ready_ff, sync2_ff[SB_RHY], rp_high_ff};
  wire irq_act = |(irq_src & irq_mode_ff[5:0]);
  assign o_interrupt_out_n = ~irq_act;

  // Data-out drive; registered so the pin never glitches between modes
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sdo_ff <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
    end else if (cs_n | cs_fall) begin
      sdo_ff <= 1'b1;
      sdo_oe_n_ff <= ~(cs_fall & irq_mux);
    end else if (read_act_ff) begin
      sdo_ff <= tx_ff[7];
      sdo_oe_n_ff <= 1'b0;
    end else if (irq_mux) begin
      sdo_ff <= ~irq_act;
      sdo_oe_n_ff <= 1'b0;
    end else if (fall_cnt_ff == `ICR_SPI_CMD_FALLS) begin
      sdo_ff <= tx_ff[7];
      sdo_oe_n_ff <= 1'b0;
    end else begin
      sdo_ff <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
    end
  end

  assign o_sdo = sdo_ff;
  assign o_sdo_oe_n = sdo_oe_n_ff;

endmodule // icr_core

// ===== shared/icr_defines.vh
`ifndef ICR_DEFINES_VH
`define ICR_DEFINES_VH

// Register offsets (7-bit SPI address space)
`define ICR_OFS_SENSOR_DRIVE 7'h01
`define ICR_OFS_DIG_CONV_CFG 7'h04
`define ICR_OFS_ALT_CFG 7'h05
`define ICR_OFS_IRQ_MODE 7'h0A
`define ICR_OFS_AMP_CFG 7'h0C
`define ICR_OFS_REFCNT_LO 7'h30
`define ICR_OFS_REFCNT_HI 7'h31
`define ICR_OFS_FOFS_LO 7'h32
`define ICR_OFS_FOFS_HI 7'h33
`define ICR_OFS_HR_CFG 7'h34
`define ICR_OFS_RES_LO 7'h38
`define ICR_OFS_RES_MID 7'h39
`define ICR_OFS_RES_HI 7'h3A

// Reset values and the lost-oscillation result
`define ICR_RST_BYTE 8'h00
`define ICR_RST_WORD 16'h0000
`define ICR_RST_RESULT 24'h000000
`define ICR_RESULT_NO_OSC 24'hFFFFFF
`define ICR_SYNC_IDLE 11'h001

// Field positions
`define ICR_IRQ_MUX_BIT 7
`define ICR_FIXED_DRIVE_BIT 0

// Timing counts
`define ICR_RESP_MIN_CYC 13'h00C0
`define ICR_RESP_DIVISOR 13'h0003
`define ICR_RESP_CODE_BASE 3'h2
`define ICR_HR_POST_CYC 20'h00037
`define ICR_HR_CNT_SHIFT 4
`define ICR_DIV_STEPS 6'h2C
`define ICR_SPI_CMD_FALLS 4'h8

`endif

// ===== sim/icr_core_bench.sv
`timescale 1ns/10ps
module icr_core_bench;
  localparam logic [5:0] FUNC [4] = '{6'h01, 6'h02, 6'h08, 6'h10};
  localparam logic [7:0] CFG [5] = '{8'h01, 8'h00, 8'hFF, 8'h00, 8'h00};
  localparam logic [2:0] RESP [3] = '{3'h0, 3'h2, 3'h3};
  logic clk, rst_n, ref_clk, ref_run, sensor, no_osc, fault;
  logic [3:0] cmp;
  logic [7:0] rx;
  logic [23:0] res;
  int n_errors, compares, ref_rises, sens_rises, t0, cyc, exp_n;
  wire cs_n, sclk, sdi, sdo, sdo_oe_n, fixed_en, irq_n, sdo_line;
  wire [2:0] code;
  wire [7:0] level;
  // Released line shows the inverse of sdo, which sits high whenever released, so a late sample reads low
  assign sdo_line = sdo_oe_n ? ~sdo : sdo;
  icr_core icr_core_inst (.i_core_clk(clk), .i_reset_n(rst_n), .i_chip_select_n(cs_n), .i_sclk(sclk),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_reference_clock_in(ref_clk), .i_sensor_osc(sensor),
    .i_no_sensor_osc(no_osc), .i_fault(fault), .i_inductance_hysteresis_compare(cmp[3]),
    .i_inductance_high_event(cmp[2]), .i_impedance_hysteresis_compare(cmp[1]), .i_impedance_high_event(cmp[0]),
    .o_fixed_drive_en(fixed_en), .o_min_impedance_drive_code(code), .o_drive_level(level),
    .o_interrupt_out_n(irq_n));
  icr_host icr_host_inst (.i_core_clk(clk), .i_sdo(sdo_line), .i_sdo_oe_n(sdo_oe_n), .o_chip_select_n(cs_n),
    .o_sclk(sclk), .o_sdi(sdi));
  // Core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Reference at 3.125 MHz, inside the allowed band and above four times the sensor
  initial begin
    ref_clk = 1'b0;
    #3;
    forever #160 ref_clk = ref_run & ~ref_clk;
  end
  // Sensor at 625 kHz, phase unrelated to both clocks
  initial begin
    sensor = 1'b0;
    #7;
    forever #800 sensor = ~sensor;
  end
  always @(posedge ref_clk) ref_rises++;
  always @(posedge sensor) sens_rises++;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    icr_host_inst.dbuf[0] = d;
    icr_host_inst.xfer(1'b0, a, 1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    icr_host_inst.xfer(1'b1, a, 1);
    d = icr_host_inst.dbuf[0];
  endtask
  // Bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic lvl);
    cyc = 0;
    while (irq_n !== lvl && cyc < 20000) begin
      tick(1);
      cyc++;
    end
    if (cyc >= 20000) begin
      n_errors++;
      $display("ERROR interrupt wait expected %0b seen timeout", lvl);
    end
  endtask
  task automatic rd_res;
    icr_host_inst.xfer(1'b1, 7'h38, 3);
    res = {icr_host_inst.dbuf[2], icr_host_inst.dbuf[1], icr_host_inst.dbuf[0]};
  endtask
  // With one reference count, result plus offset times 256 is a whole number of edges times 2^20
  task automatic check_count(input int lo, input int hi);
    logic [23:0] sum;
    sum = res + 24'h00FF00;
    check("result fraction", 24'h0, {4'h0, sum[19:0]});
    check("result edge count", 24'h1, 24'(sum[23:20] >= lo && sum[23:20] <= hi));
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    print_verdict();
  end
  initial begin
    {rst_n, ref_run, no_osc, fault, cmp} = 8'h00;
    tick(8);
    rst_n = 1'b1;
    // No comparator latch may be set by the release of reset
    wr(7'h0A, 8'h09);
    check("latches after reset", 1'b1, irq_n);
    // Registers, refusals and data-out float
    rd(7'h01, rx);
    check("drive setting reset", 8'h00, rx);
    rd(7'h7F, rx);
    check("unmapped read", 8'h00, rx);
    wr(7'h38, 8'h55);
    rd(7'h38, rx);
    check("result before conversion", 8'h00, rx);
    check("float during command", 8'hFF, icr_host_inst.cmd_oe);
    check("drive during data", 8'h00, icr_host_inst.oe_seen);
    foreach (CFG[k]) icr_host_inst.dbuf[k] = CFG[k];
    icr_host_inst.xfer(1'b0, 7'h30, 5);
    icr_host_inst.xfer(1'b1, 7'h30, 5);
    foreach (CFG[k]) check("config readback", CFG[k], icr_host_inst.dbuf[k]);
    wr(7'h0A, 8'h80);
    rd(7'h04, rx);
    check("held high in command", 8'hFF, icr_host_inst.cmd_rx);
    check("driven in command", 8'h00, icr_host_inst.cmd_oe);
    wr(7'h0A, 8'h90);
    cmp = 4'h8;
    rd(7'h04, rx);
    check("event in command", 8'h00, icr_host_inst.cmd_rx);
    cmp = 4'h0;
    $display("test registers and data-out done");
    // Comparator sources: levels follow the input, latches hold until cleared
    for (int k = 0; k < 4; k++) begin
      wr(7'h0A, {2'b00, FUNC[k]});
      cmp = 4'h1 << k;
      tick(6);
      check("source asserted", 1'b0, irq_n);
      cmp = 4'h0;
      tick(6);
      check("source after input drops", 24'(k % 2), irq_n);
      wr(7'h0A, 8'h00);
      wr(7'h0A, {2'b00, FUNC[k]});
      check("source cleared", 1'b1, irq_n);
    end
    $display("test interrupt sources done");
    wr(7'h05, 8'h01);
    check("fixed drive needs both bits", 1'b0, fixed_en);
    wr(7'h0C, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(7'h01, 8'(c));
      check("fixed drive on", 1'b1, fixed_en);
      check("drive code", 24'(c), code);
      check("drive level", 24'h1 << c, level);
    end
    wr(7'h05, 8'h00);
    check("drive level off", 8'h00, level);
    $display("test fixed drive done");
    // High-resolution conversions, ready shown on data-out
    wr(7'h0A, 8'hA0);
    tick(800);
    check("no conversion without reference", 1'b1, irq_n);
    t0 = ref_rises;
    ref_run = 1'b1;
    wait_irq(1'b0);
    check("conversion length", 24'h1, 24'(ref_rises - t0 >= 70 && ref_rises - t0 <= 74));
    rd_res;
    check("ready on data-out", 8'h00, icr_host_inst.cmd_rx);
    check_count(3, 4);
    check("ready cleared by read", 1'b1, irq_n);
    wr(7'h34, 8'h01);
    wait_irq(1'b0);
    rd_res;
    wait_irq(1'b0);
    rd_res;
    check_count(1, 2);
    fault = 1'b1;
    wait_irq(1'b0);
    rd_res;
    check("result on fault", 24'h0, res);
    fault = 1'b0;
    no_osc = 1'b1;
    wait_irq(1'b0);
    rd_res;
    check("result on lost oscillation", 24'hFFFFFF, res);
    no_osc = 1'b0;
    ref_run = 1'b0;
    $display("test high resolution done");
    // Dual conversion pulse spacing in sensor edges
    wr(7'h0A, 8'h04);
    foreach (RESP[i]) begin
      exp_n = (RESP[i] < 3'h2 ? 192 : 192 << (RESP[i] - 3'h2)) / 3;
      wr(7'h04, {5'h00, RESP[i]});
      wait_irq(1'b0);
      wait_irq(1'b1);
      t0 = sens_rises;
      wait_irq(1'b0);
      check("dual interval", 24'h1, 24'(sens_rises - t0 >= exp_n - 1 && sens_rises - t0 <= exp_n + 1));
    end
    $display("test dual conversion done");
    print_verdict();
  end
endmodule // icr_core_bench

// ===== sim/icr_core_sva.sv
`timescale 1ns/10ps
module icr_core_sva (
  // Clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // Watched pins
  input wire i_chip_select_n,
  input wire o_sdo_oe_n,
  input wire o_fixed_drive_en,
  input wire [2:0] o_min_impedance_drive_code,
  input wire [7:0] o_drive_level,
  input wire o_interrupt_out_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Drive level is one-hot on the code only while fixed drive is on
  drive_on_a: assert property (o_fixed_drive_en |-> o_drive_level == (8'h01 << o_min_impedance_drive_code))
    else $error("drive level does not match code");
  drive_off_a: assert property (!o_fixed_drive_en |-> o_drive_level == 8'h00)
    else $error("drive level without fixed drive");
  // Settings only move inside a transfer, never while deselected
  cfg_stable_a: assert property (i_chip_select_n [*8] |=> $stable(o_fixed_drive_en) && $stable(o_drive_level))
    else $error("drive settings moved while deselected");
  // Long deselect always leaves data-out floating
  sdo_idle_a: assert property (i_chip_select_n [*8] |-> o_sdo_oe_n)
    else $error("data-out driven while deselected");
  // Data-out only starts driving inside a selected frame
  sdo_start_a: assert property ($fell(o_sdo_oe_n) |-> !$past(i_chip_select_n, 2))
    else $error("data-out driven without select");
  sdo_hold_a: assert property (!o_sdo_oe_n && !i_chip_select_n |=> !o_sdo_oe_n)
    else $error("data-out released inside frame");
  sdo_release_a: assert property ($rose(o_sdo_oe_n) |-> $past(i_chip_select_n, 2))
    else $error("data-out released before deselect");
  // Quiet pins right after reset
  rst_state_a: assert property ($rose(i_reset_n) |-> o_sdo_oe_n && o_interrupt_out_n && !o_fixed_drive_en)
    else $error("outputs not idle after reset");
endmodule // icr_core_sva

bind icr_core icr_core_sva icr_core_sva_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_chip_select_n(i_chip_select_n), .o_sdo_oe_n(o_sdo_oe_n), .o_fixed_drive_en(o_fixed_drive_en),
  .o_min_impedance_drive_code(o_min_impedance_drive_code), .o_drive_level(o_drive_level),
  .o_interrupt_out_n(o_interrupt_out_n));

// ===== sim/icr_host.sv
`timescale 1ns/10ps
module icr_host (
  // Pacing clock
  input wire i_core_clk,
  // Data-out wire and its enable
  input wire i_sdo,
  input wire i_sdo_oe_n,
  // Host drive
  output logic o_chip_select_n,
  output logic o_sclk,
  output logic o_sdi
);
  logic [7:0] dbuf [0:7];
  logic [7:0] oe_seen, cmd_rx, cmd_oe;
  // Idle: deselected, clock parked low between frames
  initial begin
    o_chip_select_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // Five core cycles per level, above the four the synchronizers need
  task automatic half;
    repeat (5) @(posedge i_core_clk);
    #1;
  endtask
  // Mode 0 byte: data set while clock low, both lines sampled on the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sdi = tx[i];
      half();
      o_sclk = 1'b1;
      rx[i] = i_sdo;
      oe_seen[i] = i_sdo_oe_n;
      half();
      o_sclk = 1'b0;
    end
  endtask
  // One frame: command byte then n data bytes, read data lands in dbuf
  task automatic xfer(input logic rd, input logic [6:0] addr, input int n);
    logic [7:0] r;
    half();
    o_chip_select_n = 1'b0;
    half();
    xbyte({rd, addr}, r);
    cmd_rx = r;
    cmd_oe = oe_seen;
    for (int k = 0; k < n; k++) begin
      xbyte(dbuf[k], r);
      dbuf[k] = r;
    end
    half();
    o_chip_select_n = 1'b1;
    o_sdi = ~o_sdi; // Released line must not keep the last bit
  endtask
endmodule // icr_host
